// ===== core/sitc_defs.svh
// Register offsets, field positions, reset values, function codes and timing
`ifndef SITC_DEFS_SVH
`define SITC_DEFS_SVH
`define SITC_A_VIN 5'h00
`define SITC_A_SLOT0 5'h01
`define SITC_SLOTS 5
`define SITC_A_DCFMT 5'h06
`define SITC_A_SSCL 5'h07
`define SITC_A_SOFS 5'h08
`define SITC_A_TSCL 5'h09
`define SITC_A_TOFS 5'h0a
`define SITC_A_ZCLP 5'h0b
`define SITC_A_SGAIN 5'h0c
`define SITC_A_TGAIN 5'h0d
`define SITC_A_PFLT 5'h0e
`define SITC_A_STAU 5'h0f
`define SITC_A_TTAU 5'h10
`define SITC_A_GNUM 5'h11
`define SITC_A_GDEN 5'h12
`define SITC_A_MODE 5'h13
`define SITC_A_STAT 5'h14
`define SITC_A_SOUT 5'h15
`define SITC_A_TOUT 5'h16
`define SITC_A_TFN0 5'h18
`define SITC_RST_SSCL 16'h0032
`define SITC_RST_TSCL 16'h001e
`define SITC_RST_GAIN 16'h2710
`define SITC_GAIN_MIN 16'h1f40
`define SITC_GAIN_MAX 16'h2ee0
`define SITC_ZCLP_MAX 16'h01f4
`define SITC_RST_PFLT 5'h05
`define SITC_PFLT_MAX 5'h13
`define SITC_RST_TAU 16'h0032
`define SITC_TOFS_MV 17'sh0000a
`define SITC_FN_ALARM 7'h45
`define SITC_FN_PULSE 7'h46
`define SITC_FN_POSD 7'h4d
`define SITC_FN_BCAST 7'h4e
`define SITC_FN_ESTOP 7'h0a
`define SITC_ST_ALARM 0
`define SITC_ST_PULSE 1
`define SITC_ST_POSD 2
`define SITC_ST_BCEN 3
`define SITC_ST_HOLD 4
`define SITC_ST_FMT 5
`define SITC_CLK_HZ 50000000
`define SITC_TICK_US 10
`define SITC_GATE_US 1000
`define SITC_SEC_PER_MIN 60
`define SITC_TRQ_FULL 1000
`endif

// ===== core/sitc_pkg.sv
// Types shared by the input terminal conditioning block
package sitc_pkg;
  typedef enum logic [1:0] {mode_pos, mode_spd, mode_trq} sitc_mode_t;
  typedef logic [6:0] sitc_fn_t;
endpackage : sitc_pkg

// ===== core/sitc_top.sv
// Input terminal conditioning: function decode, command pulse and analog paths
// Notes on behaviour
// [RL1] External alarm function raises the fault alarm
// [RL2] Pulse speed input selects pulse-derived speed
// [RL3] Pulse rpm uses frequency, gear, encoder resolution
// [RL4] Positioning-data input picks stored points
// [RL5] Broadcast cancel drops broadcast queries silently
// [RL6] Cancel in permanent slot disables broadcast
// [RL7] Virtual byte ORs onto terminals one-to-eight
// [RL8] Five permanent slots force functions
// [RL9] Host keeps forbidden functions out of slots
// [RL10] Terminal and slot assignment combine
// [RL11] Speeds under clamp level become zero; torque mode is left unclamped
// [RL12] Deviation clear by edge or level
// [RL13] Speed command fine gain 0.8 to 1.2
// [RL14] Torque command fine gain 0.8 to 1.2
// [RL15] Pulse filter from twenty entry table
// [RL16] Speed command scale and millivolt offset
// [RL17] Torque command scale and ten-millivolt offset
// [RL18] Speed command first-order smoothing
// [RL19] Torque command first-order smoothing
// [RL20] Power-cycle settings apply after restart only
//
// Our own choices: the register offsets and strobed register access.
`include "sitc_defs.svh"
module sitc_top
  import sitc_pkg::*;
#(
  parameter int RATED_RPM = 3000,
  parameter int ENC_BITS = 20,
  parameter int GATE_CYC = `SITC_CLK_HZ / 1000000 * `SITC_GATE_US,
  parameter sitc_fn_t FN_SEL_A = 7'h03,
  parameter sitc_fn_t FN_SEL_B = 7'h04,
  parameter sitc_fn_t FN_SEL_C = 7'h05,
  parameter sitc_fn_t FN_ARST = 7'h0b,
  parameter sitc_fn_t FN_DCLR = 7'h0c,
  parameter sitc_fn_t FN_POT = 7'h07,
  parameter sitc_fn_t FN_NOT = 7'h08
) (
  // Clock and reset
  input logic mclk,
  input logic rst_b,
  // Register port
  input logic [4:0] reg_addr,
  input logic [15:0] reg_wdata,
  input logic reg_wr,
  input logic reg_rd,
  output logic [15:0] reg_rdata,
  // Pins
  input logic [7:0] input_terminal,
  input logic cmd_pulse,
  input logic soft_restart,
  // Converted analog samples in mV
  input logic signed [15:0] speed_adc,
  input logic signed [15:0] analog_torque_voltage,
  // Query screening
  input logic query_valid,
  input logic query_bcast,
  output logic query_accept,
  output logic query_discard,
  // Decoded functions
  output logic external_fault_alarm,
  output logic pulse_speed_active,
  output logic positioning_data_sel,
  output logic broadcast_enable,
  output logic positive_overtravel,
  output logic negative_overtravel,
  output logic dev_clear_pulse,
  output logic zero_speed_hold,
  // Commands
  output logic signed [15:0] speed_cmd,
  output logic signed [15:0] torque_cmd
);
  localparam int TICK_CYC = `SITC_CLK_HZ / 1000000 * `SITC_TICK_US;
  localparam int RPM_K = `SITC_SEC_PER_MIN * 1000000 / `SITC_GATE_US;

  if (ENC_BITS < 1 || ENC_BITS > 30 || GATE_CYC < 2 || GATE_CYC > 65535) begin : g_chk
    $error("sitc_top: unsupported parameter value");
  end

  function automatic logic fn_on(sitc_fn_t n, logic [7:0] lv, logic [55:0] tf, logic [34:0] sl);
    logic on;
    logic nc;
    on = 1'b0;
    nc = (n == FN_POT) || (n == FN_NOT) || (n == `SITC_FN_ESTOP);
    for (int i = 0; i < 8; i++) begin
      if (n != '0 && tf[i*7 +: 7] == n && lv[i]) on = 1'b1; // see [RL10]
    end
    for (int j = 0; j < `SITC_SLOTS; j++) begin
      if (n != '0 && sl[j*7 +: 7] == n) on = !nc; // see [RL8]
    end
    return on;
  endfunction : fn_on

  // Half of the filter period, so a pulse level must stand that long
  function automatic logic [10:0] filt_cyc(logic [4:0] s);
    int hz;
    case (s)
      5'h00: hz = 1250000;
      5'h01: hz = 937500;
      5'h02: hz = 625000;
      5'h03: hz = 468700;
      5'h04: hz = 312500;
      5'h05: hz = 234400;
      5'h06: hz = 156300;
      5'h07: hz = 117200;
      5'h08: hz = 78100;
      5'h09: hz = 58600;
      5'h0a: hz = 46900;
      5'h0b: hz = 39100;
      5'h0c: hz = 29300;
      5'h0d: hz = 23400;
      5'h0e: hz = 19500;
      5'h0f: hz = 14600;
      5'h10: hz = 15000000;
      5'h11: hz = 7500000;
      5'h12: hz = 3750000;
      default: hz = 1875000;
    endcase
    return (hz >= `SITC_CLK_HZ / 2) ? 11'h001 : 11'(`SITC_CLK_HZ / (2 * hz));
  endfunction : filt_cyc

  function automatic logic signed [31:0] ana_cmd(logic signed [16:0] mv, logic [15:0] gain,
                                                 logic signed [15:0] scl, int full);
    logic signed [47:0] t;
    logic signed [47:0] d;
    t = 48'(mv) * $signed({32'h0, gain});
    t = t / 48'sd10000;
    t = t * 48'(full);
    d = (scl == 16'sh0) ? 48'sd100 : 48'(scl) * 48'sd100;
    t = t / d;
    return 32'(t);
  endfunction : ana_cmd

  function automatic logic signed [15:0] sat16(logic signed [31:0] x);
    if (x > 32'sd32767) return 16'sh7fff;
    if (x < -32'sd32767) return -16'sh7fff;
    return 16'(x);
  endfunction : sat16

  // State carries 8 fraction bits so small residues still decay
  function automatic logic signed [23:0] lp(logic signed [23:0] y, logic signed [15:0] x, logic [15:0] tau);
    logic signed [24:0] dif;
    dif = 25'($signed({x, 8'h00})) - 25'(y);
    if (tau == 16'h0) return {x, 8'h00};
    return y + 24'(dif / $signed({9'h0, tau}));
  endfunction : lp

  function automatic logic [15:0] gain_clip(logic [15:0] g);
    if (g < `SITC_GAIN_MIN) return `SITC_GAIN_MIN;
    if (g > `SITC_GAIN_MAX) return `SITC_GAIN_MAX;
    return g;
  endfunction : gain_clip

  // Pin synchronisers
  logic [7:0] term_s1_reg, term_s2_reg;
  logic pls_s1_reg, pls_s2_reg, rsr_s1_reg, rsr_s2_reg, rsr_d_reg;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      term_s1_reg <= 8'h00;
      term_s2_reg <= 8'h00;
      pls_s1_reg <= 1'b0;
      pls_s2_reg <= 1'b0;
      rsr_s1_reg <= 1'b0;
      rsr_s2_reg <= 1'b0;
      rsr_d_reg <= 1'b0;
    end else begin
      term_s1_reg <= input_terminal;
      term_s2_reg <= term_s1_reg;
      pls_s1_reg <= cmd_pulse;
      pls_s2_reg <= pls_s1_reg;
      rsr_s1_reg <= soft_restart;
      rsr_s2_reg <= rsr_s1_reg;
      rsr_d_reg <= rsr_s2_reg;
    end
  end
  logic restart;
  assign restart = rsr_s2_reg & ~rsr_d_reg;

  // Software registers
  logic [7:0] virtual_input_byte_reg;
  sitc_fn_t slot_stg_reg [`SITC_SLOTS];
  sitc_fn_t slot_act_reg [`SITC_SLOTS];
  sitc_fn_t tfn_reg [8];
  logic dcf_stg_reg, dcf_act_reg;
  logic signed [15:0] sscl_reg, sofs_reg, tscl_reg, tofs_reg;
  logic [15:0] zclp_reg, sgain_reg, tgain_reg, stau_reg, ttau_reg, gnum_reg, gden_reg;
  logic [4:0] pflt_reg;
  sitc_mode_t mode_reg;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      virtual_input_byte_reg <= 8'h00;
      for (int i = 0; i < `SITC_SLOTS; i++) slot_stg_reg[i] <= 7'h00;
      for (int i = 0; i < 8; i++) tfn_reg[i] <= 7'h00;
      dcf_stg_reg <= 1'b0;
      sscl_reg <= `SITC_RST_SSCL;
      sofs_reg <= 16'sh0000;
      tscl_reg <= `SITC_RST_TSCL;
      tofs_reg <= 16'sh0000;
      zclp_reg <= 16'h0000;
      sgain_reg <= `SITC_RST_GAIN;
      tgain_reg <= `SITC_RST_GAIN;
      pflt_reg <= `SITC_RST_PFLT;
      stau_reg <= `SITC_RST_TAU;
      ttau_reg <= `SITC_RST_TAU;
      gnum_reg <= 16'h0001;
      gden_reg <= 16'h0001;
      mode_reg <= mode_pos;
    end else if (reg_wr) begin
      if (reg_addr >= `SITC_A_SLOT0 && reg_addr < `SITC_A_DCFMT) begin
        slot_stg_reg[3'(reg_addr - `SITC_A_SLOT0)] <= reg_wdata[6:0];
      end
      if (reg_addr >= `SITC_A_TFN0) tfn_reg[reg_addr[2:0]] <= reg_wdata[6:0];
      case (reg_addr)
        `SITC_A_VIN: virtual_input_byte_reg <= reg_wdata[7:0];
        `SITC_A_DCFMT: dcf_stg_reg <= reg_wdata[0];
        `SITC_A_SSCL: sscl_reg <= reg_wdata;
        `SITC_A_SOFS: sofs_reg <= reg_wdata;
        `SITC_A_TSCL: tscl_reg <= reg_wdata;
        `SITC_A_TOFS: tofs_reg <= reg_wdata;
        `SITC_A_ZCLP: zclp_reg <= (reg_wdata > `SITC_ZCLP_MAX) ? `SITC_ZCLP_MAX : reg_wdata;
        `SITC_A_SGAIN: sgain_reg <= gain_clip(reg_wdata); // see [RL13]
        `SITC_A_TGAIN: tgain_reg <= gain_clip(reg_wdata); // see [RL14]
        `SITC_A_PFLT: pflt_reg <= (reg_wdata > 16'h0013) ? `SITC_PFLT_MAX : reg_wdata[4:0]; // see [RL15]
        `SITC_A_STAU: stau_reg <= reg_wdata;
        `SITC_A_TTAU: ttau_reg <= reg_wdata;
        `SITC_A_GNUM: gnum_reg <= reg_wdata;
        `SITC_A_GDEN: gden_reg <= reg_wdata;
        `SITC_A_MODE: if (reg_wdata[1:0] != 2'h3) mode_reg <= sitc_mode_t'(reg_wdata[1:0]);
        default: ;
      endcase
    end
  end

  // Power-cycle settings are only taken at a restart, never on write
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < `SITC_SLOTS; i++) slot_act_reg[i] <= 7'h00;
      dcf_act_reg <= 1'b0;
    end else if (restart) begin // see [RL20]
      for (int i = 0; i < `SITC_SLOTS; i++) slot_act_reg[i] <= slot_stg_reg[i];
      dcf_act_reg <= dcf_stg_reg;
    end
  end

  // Function decode
  logic [7:0] lv;
  logic [55:0] tf_p;
  logic [34:0] sl_p;
  always_comb begin
    for (int i = 0; i < 8; i++) tf_p[i*7 +: 7] = tfn_reg[i];
    for (int j = 0; j < `SITC_SLOTS; j++) sl_p[j*7 +: 7] = slot_act_reg[j];
  end
  assign lv = term_s2_reg | virtual_input_byte_reg; // see [RL7]
  logic f_alarm, f_pulse, f_posd, f_bcc, f_sel_a, f_sel_b, f_sel_c, f_arst, f_dclr, f_pot, f_not;
  assign f_alarm = fn_on(`SITC_FN_ALARM, lv, tf_p, sl_p);
  assign f_pulse = fn_on(`SITC_FN_PULSE, lv, tf_p, sl_p);
  assign f_posd = fn_on(`SITC_FN_POSD, lv, tf_p, sl_p);
  assign f_bcc = fn_on(`SITC_FN_BCAST, lv, tf_p, sl_p); // see [RL6]
  assign f_sel_a = fn_on(FN_SEL_A, lv, tf_p, sl_p);
  assign f_sel_b = fn_on(FN_SEL_B, lv, tf_p, sl_p);
  assign f_sel_c = fn_on(FN_SEL_C, lv, tf_p, sl_p);
  assign f_arst = fn_on(FN_ARST, lv, tf_p, sl_p);
  assign f_dclr = fn_on(FN_DCLR, lv, tf_p, sl_p);
  assign f_pot = fn_on(FN_POT, lv, tf_p, sl_p);
  assign f_not = fn_on(FN_NOT, lv, tf_p, sl_p);
  logic sel_pulse;
  assign sel_pulse = (mode_reg == mode_spd) && !f_sel_a && !f_sel_b && !f_sel_c && f_pulse; // see [RL2]

  // Alarm stays until an alarm reset edge; a new alarm wins
  logic arst_d_reg, dclr_d_reg;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      external_fault_alarm <= 1'b0;
      arst_d_reg <= 1'b0;
    end else begin
      arst_d_reg <= f_arst;
      if (f_alarm) external_fault_alarm <= 1'b1; // see [RL1]
      else if (f_arst && !arst_d_reg) external_fault_alarm <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pulse_speed_active <= 1'b0;
      positioning_data_sel <= 1'b0;
      broadcast_enable <= 1'b1;
      positive_overtravel <= 1'b0;
      negative_overtravel <= 1'b0;
      dclr_d_reg <= 1'b0;
      dev_clear_pulse <= 1'b0;
      zero_speed_hold <= 1'b0;
    end else begin
      pulse_speed_active <= sel_pulse;
      positioning_data_sel <= f_posd; // see [RL4]
      broadcast_enable <= !f_bcc; // see [RL5]
      positive_overtravel <= f_pot;
      negative_overtravel <= f_not;
      dclr_d_reg <= f_dclr;
      dev_clear_pulse <= !dcf_act_reg && f_dclr && !dclr_d_reg; // see [RL12]
      zero_speed_hold <= dcf_act_reg && f_dclr; // see [RL12]
    end
  end

  // Unicast always passes; broadcast only while cancel is off
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      query_accept <= 1'b0;
      query_discard <= 1'b0;
    end else begin
      query_accept <= query_valid && !(query_bcast && f_bcc); // see [RL5]
      query_discard <= query_valid && query_bcast && f_bcc; // see [RL5]
    end
  end

  // Command pulse filter and rate gate
  logic [10:0] fcnt_reg;
  logic pf_reg, pf_d_reg;
  logic [15:0] gcnt_reg, pcnt_reg;
  logic signed [15:0] prpm_reg;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      fcnt_reg <= 11'h000;
      pf_reg <= 1'b0;
    end else if (pls_s2_reg == pf_reg) begin
      fcnt_reg <= 11'h000;
    end else if (fcnt_reg + 11'h001 >= filt_cyc(pflt_reg)) begin // see [RL15]
      pf_reg <= pls_s2_reg;
      fcnt_reg <= 11'h000;
    end else begin
      fcnt_reg <= fcnt_reg + 11'h001;
    end
  end
  logic [47:0] pprod, pdiv;
  assign pprod = 48'(pcnt_reg) * 48'(RPM_K) * 48'(gnum_reg);
  assign pdiv = (pprod / 48'((gden_reg == 16'h0) ? 16'h0001 : gden_reg)) >> ENC_BITS; // see [RL3]
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pf_d_reg <= 1'b0;
      gcnt_reg <= 16'h0000;
      pcnt_reg <= 16'h0000;
      prpm_reg <= 16'sh0000;
    end else begin
      pf_d_reg <= pf_reg;
      if (gcnt_reg == 16'(GATE_CYC - 1)) begin
        gcnt_reg <= 16'h0000;
        pcnt_reg <= {15'h0000, pf_reg & ~pf_d_reg};
        prpm_reg <= (pdiv > 48'h7fff) ? 16'sh7fff : 16'(pdiv); // see [RL3]
      end else begin
        gcnt_reg <= gcnt_reg + 16'h0001;
        if (pf_reg && !pf_d_reg && pcnt_reg != 16'hffff) pcnt_reg <= pcnt_reg + 16'h0001;
      end
    end
  end

  // Analog paths, sampled on a 10 us tick
  logic [9:0] tick_reg;
  logic signed [23:0] sy_reg, ty_reg;
  logic signed [15:0] s_raw, t_raw, s_sel;
  assign s_raw = sat16(ana_cmd(17'(speed_adc) - 17'(sofs_reg), sgain_reg, sscl_reg, RATED_RPM)); // see [RL16]
  assign t_raw = sat16(ana_cmd(17'(analog_torque_voltage) - 17'(tofs_reg) * `SITC_TOFS_MV,
                               tgain_reg, tscl_reg, `SITC_TRQ_FULL)); // see [RL17]
  assign s_sel = sel_pulse ? prpm_reg : sy_reg[23:8];
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      tick_reg <= 10'h000;
      sy_reg <= 24'sh000000;
      ty_reg <= 24'sh000000;
    end else if (tick_reg == 10'(TICK_CYC - 1)) begin
      tick_reg <= 10'h000;
      sy_reg <= lp(sy_reg, s_raw, stau_reg); // see [RL18]
      ty_reg <= lp(ty_reg, t_raw, ttau_reg); // see [RL19]
    end else begin
      tick_reg <= tick_reg + 10'h001;
    end
  end

  // Outside torque mode the clamp acts on the final command, so offsets cannot bypass it
  logic [15:0] s_abs;
  assign s_abs = s_sel[15] ? 16'(-s_sel) : 16'(s_sel);
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      speed_cmd <= 16'sh0000;
      torque_cmd <= 16'sh0000;
    end else begin
      speed_cmd <= (mode_reg != mode_trq && s_abs < zclp_reg) ? 16'sh0000 : s_sel; // see [RL11]
      torque_cmd <= ty_reg[23:8];
    end
  end

  // Register read, one cycle after the strobe; unmapped reads zero
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 16'h0000;
    end else if (!reg_rd) begin
      reg_rdata <= 16'h0000;
    end else if (reg_addr >= `SITC_A_SLOT0 && reg_addr < `SITC_A_DCFMT) begin
      reg_rdata <= {9'h000, slot_stg_reg[3'(reg_addr - `SITC_A_SLOT0)]};
    end else if (reg_addr >= `SITC_A_TFN0) begin
      reg_rdata <= {9'h000, tfn_reg[reg_addr[2:0]]};
    end else begin
      case (reg_addr)
        `SITC_A_VIN: reg_rdata <= {8'h00, virtual_input_byte_reg};
        `SITC_A_DCFMT: reg_rdata <= {15'h0000, dcf_stg_reg};
        `SITC_A_SSCL: reg_rdata <= sscl_reg;
        `SITC_A_SOFS: reg_rdata <= sofs_reg;
        `SITC_A_TSCL: reg_rdata <= tscl_reg;
        `SITC_A_TOFS: reg_rdata <= tofs_reg;
        `SITC_A_ZCLP: reg_rdata <= zclp_reg;
        `SITC_A_SGAIN: reg_rdata <= sgain_reg;
        `SITC_A_TGAIN: reg_rdata <= tgain_reg;
        `SITC_A_PFLT: reg_rdata <= {11'h000, pflt_reg};
        `SITC_A_STAU: reg_rdata <= stau_reg;
        `SITC_A_TTAU: reg_rdata <= ttau_reg;
        `SITC_A_GNUM: reg_rdata <= gnum_reg;
        `SITC_A_GDEN: reg_rdata <= gden_reg;
        `SITC_A_MODE: reg_rdata <= {14'h0000, mode_reg};
        `SITC_A_STAT: reg_rdata <= {10'h000, dcf_act_reg, zero_speed_hold, broadcast_enable,
                                    positioning_data_sel, pulse_speed_active, external_fault_alarm};
        `SITC_A_SOUT: reg_rdata <= speed_cmd;
        `SITC_A_TOUT: reg_rdata <= torque_cmd;
        default: reg_rdata <= 16'h0000;
      endcase
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  sequence s_dclr_rise;
    !f_dclr ##1 f_dclr && !dcf_act_reg;
  endsequence
  sequence s_bc_query;
    query_valid && query_bcast && f_bcc;
  endsequence
  a_alarm_raise: assert property (f_alarm |=> external_fault_alarm) // see [RL1]
    else $error("external alarm not held");
  a_bcast_drop: assert property (s_bc_query |=> // see [RL5]
                                 query_discard && !query_accept ##1 (!query_discard || $past(query_valid)))
    else $error("broadcast query not discarded");
  a_unicast_pass: assert property (query_valid && !query_bcast |=> query_accept && !query_discard) // see [RL5]
    else $error("unicast query refused");
  a_slot_cancel: assert property (slot_act_reg[0] == `SITC_FN_BCAST |=> !broadcast_enable) // see [RL6]
    else $error("broadcast enabled with cancel slot");
  a_virt_alarm: assert property (virtual_input_byte_reg[0] && tfn_reg[0] == `SITC_FN_ALARM
                                 |=> external_fault_alarm) // see [RL7]
    else $error("virtual input not merged");
  a_dclr_edge: assert property (s_dclr_rise |=> dev_clear_pulse ##1 !dev_clear_pulse) // see [RL12]
    else $error("deviation clear pulse wrong");
  a_zero_clamp: assert property ($past(mode_reg) != mode_trq && speed_cmd != 16'sh0
                                 |-> (speed_cmd[15] ? 16'(-speed_cmd) : 16'(speed_cmd)) >= $past(zclp_reg)) // see [RL11]
    else $error("speed below clamp level");
  a_gain_range: assert property (sgain_reg >= `SITC_GAIN_MIN && sgain_reg <= `SITC_GAIN_MAX
                                 && tgain_reg >= `SITC_GAIN_MIN && tgain_reg <= `SITC_GAIN_MAX) // see [RL13]
    else $error("fine gain out of range");
  a_pwr_cycle: assert property (!restart |=> $stable(dcf_act_reg) && $stable(slot_act_reg[0])) // see [RL20]
    else $error("power-cycle setting changed without restart");
  a_filt_sel: assert property (pflt_reg <= `SITC_PFLT_MAX) // see [RL15]
    else $error("filter select out of table");
endmodule : sitc_top

// ===== verification/sitc_host_model.sv
// Host controller model driving the discrete input terminals
module sitc_host_model #(
  parameter int LAG = 2
) (
  // Clock
  input logic mclk,
  // Levels the bench asks for
  input logic [7:0] want,
  input logic pulse_run,
  // Pins
  output logic [7:0] input_terminal,
  output logic cmd_pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] pipe [LAG];
  initial begin
    for (int i = 0; i < LAG; i++) pipe[i] = 8'h00;
  end
  // Slow host: pins settle LAG cycles after the request
  always @(posedge mclk) begin
    pipe[0] <= want;
    for (int i = 1; i < LAG; i++) pipe[i] <= pipe[i-1];
  end
  assign input_terminal = pipe[LAG-1];
  // Four-cycle pulse train while enabled; the line rests low otherwise
  logic tog_reg = 1'b0;
  logic pls_reg = 1'b0;
  always @(posedge mclk) begin
    tog_reg <= ~tog_reg;
    if (!pulse_run) pls_reg <= 1'b0;
    else if (tog_reg) pls_reg <= ~pls_reg;
  end
  assign cmd_pulse = pls_reg;
endmodule : sitc_host_model

// ===== verification/servo_input_terminal_conditioning_bench.sv
// Self-checking bench for the input terminal conditioning block
`include "sitc_defs.svh"
module servo_input_terminal_conditioning_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, rst_b, reg_wr, reg_rd, cmd_pulse, soft_restart, query_valid, query_bcast, pulse_run;
  logic [4:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, d;
  logic [7:0] input_terminal, want;
  logic query_accept, query_discard, alarm, pulse_act, posd, bc_en, dclr, hold, pos_ot, neg_ot;
  logic signed [15:0] speed_cmd, torque_cmd, spd_v, trq_v;
  int err_count, comparisons, npulse;
  sitc_host_model #(.LAG(3)) host_u (.mclk(mclk), .want(want), .pulse_run(pulse_run),
    .input_terminal(input_terminal), .cmd_pulse(cmd_pulse));
  sitc_top #(.GATE_CYC(100)) dut_u (.mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .input_terminal(input_terminal), .cmd_pulse(cmd_pulse), .soft_restart(soft_restart),
    .speed_adc(spd_v), .analog_torque_voltage(trq_v), .query_valid(query_valid),
    .query_bcast(query_bcast), .query_accept(query_accept), .query_discard(query_discard),
    .external_fault_alarm(alarm), .pulse_speed_active(pulse_act), .positioning_data_sel(posd),
    .broadcast_enable(bc_en), .positive_overtravel(pos_ot), .negative_overtravel(neg_ot),
    .dev_clear_pulse(dclr), .zero_speed_hold(hold), .speed_cmd(speed_cmd), .torque_cmd(torque_cmd));
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : cyc
  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [4:0] a);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd
  // Expects {accept, discard} one cycle after the query edge
  task automatic query(input logic b, input logic [1:0] exp);
    @(posedge mclk);
    query_valid <= 1'b1;
    query_bcast <= b;
    @(posedge mclk);
    query_valid <= 1'b0;
    #1;
    chk({query_accept, query_discard}, exp);
  endtask : query
  // Stands in for a power cycle of the drive
  task automatic restart();
    @(posedge mclk);
    soft_restart <= 1'b1;
    cyc(4);
    soft_restart <= 1'b0;
    cyc(6);
  endtask : restart
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : stop_test
  logic [4:0] ra [10] = '{`SITC_A_SGAIN, `SITC_A_TGAIN, `SITC_A_SSCL, `SITC_A_TSCL, `SITC_A_PFLT,
    `SITC_A_STAU, `SITC_A_TTAU, `SITC_A_VIN, 5'h17, `SITC_A_STAT};
  logic [15:0] rv [10] = '{`SITC_RST_GAIN, `SITC_RST_GAIN, `SITC_RST_SSCL, `SITC_RST_TSCL, 16'h0005,
    `SITC_RST_TAU, `SITC_RST_TAU, 16'h0000, 16'h0000, 16'h0008};
  initial begin
    {rst_b, reg_wr, reg_rd, soft_restart, query_valid, query_bcast, pulse_run} = 7'h00;
    reg_addr = 5'h00;
    reg_wdata = 16'h0000;
    want = 8'h00;
    spd_v = 16'sh0000;
    trq_v = 16'sh0000;
    repeat (16) @(posedge mclk);
    rst_b <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      rd(ra[i]);
      chk(d, rv[i]);
    end
    $display("test reset values done");
    wr(`SITC_A_SGAIN, 16'h0000);
    rd(`SITC_A_SGAIN);
    chk(d, `SITC_GAIN_MIN);
    wr(`SITC_A_TGAIN, 16'hffff);
    rd(`SITC_A_TGAIN);
    chk(d, `SITC_GAIN_MAX);
    wr(`SITC_A_ZCLP, 16'h03e8);
    rd(`SITC_A_ZCLP);
    chk(d, `SITC_ZCLP_MAX);
    wr(`SITC_A_PFLT, 16'h001f);
    rd(`SITC_A_PFLT);
    chk(d, 16'h0013);
    $display("test range limits done");
    wr(`SITC_A_TFN0, 16'h0045);
    wr(`SITC_A_VIN, 16'h0001);
    cyc(2);
    chk(alarm, 1'b1);
    wr(`SITC_A_TFN0 + 5'h07, 16'h004d);
    wr(`SITC_A_VIN, 16'h0080);
    cyc(2);
    chk(posd, 1'b1);
    wr(`SITC_A_VIN, 16'h0000);
    cyc(2);
    chk(posd, 1'b0);
    wr(`SITC_A_MODE, 16'h0001);
    wr(`SITC_A_TFN0 + 5'h03, 16'h0046);
    wr(`SITC_A_TFN0 + 5'h04, 16'h0003);
    wr(`SITC_A_VIN, 16'h0008);
    cyc(2);
    chk(pulse_act, 1'b1);
    wr(`SITC_A_VIN, 16'h0018);
    cyc(2);
    chk(pulse_act, 1'b0);
    $display("test virtual inputs done");
    wr(`SITC_A_TFN0 + 5'h01, 16'h004e);
    want <= 8'h02;
    cyc(8);
    chk(bc_en, 1'b0);
    query(1'b1, 2'b01);
    query(1'b0, 2'b10);
    want <= 8'h00;
    cyc(8);
    query(1'b1, 2'b10);
    $display("test broadcast cancel done");
    // Only cancel and overtravel go into slots: forbidden ones stay out
    wr(`SITC_A_SLOT0, 16'h004e);
    wr(`SITC_A_SLOT0 + 5'h01, 16'h0007);
    wr(`SITC_A_TFN0 + 5'h05, 16'h0007);
    wr(`SITC_A_TFN0 + 5'h06, 16'h0008);
    wr(`SITC_A_VIN, 16'h0078);
    wr(`SITC_A_DCFMT, 16'h0001);
    cyc(3);
    chk(bc_en, 1'b1);
    chk(pos_ot, 1'b1);
    chk(neg_ot, 1'b1);
    restart();
    chk(bc_en, 1'b0);
    chk(pos_ot, 1'b0);
    chk(neg_ot, 1'b1);
    rd(`SITC_A_STAT);
    chk(d & 16'h0028, 16'h0020);
    wr(`SITC_A_TFN0 + 5'h02, 16'h000c);
    want <= 8'h06;
    cyc(8);
    chk(hold, 1'b1);
    chk(bc_en, 1'b0);
    $display("test power cycle settings done");
    want <= 8'h00;
    wr(`SITC_A_DCFMT, 16'h0000);
    restart();
    npulse = 0;
    want <= 8'h04;
    repeat (12) begin
      cyc(1);
      if (dclr === 1'b1) npulse++;
    end
    chk(16'(npulse), 16'h0001);
    chk(hold, 1'b0);
    $display("test edge clear done");
    // Pass-through smoothing so one 10 us tick settles both commands
    wr(`SITC_A_STAU, 16'h0000);
    wr(`SITC_A_TTAU, 16'h0000);
    spd_v <= 16'sh1388;
    trq_v <= 16'sh0bb8;
    cyc(510);
    // 5000 mV, gain 0.8, 5.0 V scale: 2400 rpm; 3000 mV, gain 1.2, 3.0 V scale: 120.0 %
    chk(speed_cmd, 16'h0960);
    chk(torque_cmd, 16'h04b0);
    wr(`SITC_A_SOFS, 16'h03e8);
    wr(`SITC_A_TOFS, 16'h000a);
    cyc(510);
    chk(speed_cmd, 16'h0780);
    chk(torque_cmd, 16'h0488);
    spd_v <= 16'sh05dc;
    cyc(510);
    // 240 rpm lies under the 500 rpm clamp
    chk(speed_cmd, 16'h0000);
    $display("test analog commands done");
    wr(`SITC_A_PFLT, 16'h0010);
    wr(`SITC_A_GNUM, 16'h4000);
    wr(`SITC_A_VIN, 16'h0008);
    pulse_run <= 1'b1;
    cyc(250);
    // 25 pulses per window: 25 * 60000 * 16384 >> 20
    chk(pulse_act, 1'b1);
    chk(speed_cmd, 16'h5b8d);
    $display("test pulse speed done");
    stop_test();
  end
  initial begin
    #200us;
    err_count++;
    stop_test();
  end
endmodule : servo_input_terminal_conditioning_bench
